// [bench/dci_partner.sv]
// far-side model: push-pull encoder pairs and a square-wave frequency source
// assumes the bench calls step and sets half; levels change after falling edges
`timescale 1ns/1ps
module dci_partner (
  // clock and frequency setting
  input wire logic clk,
  input wire logic [8:0] half,
  // sources
  output logic enc_a,
  output logic enc_b,
  output logic opt_a,
  output logic opt_b,
  output logic freq
);
  int cnt = 0;

  // all lines idle low at power-up
  initial begin
    {enc_a, enc_b, opt_a, opt_b, freq} = 5'h00;
  end

  // one quarter step, a leads b going up; both toggles together on demand
  // each level held 120 cycles, longer than the minimum high time
  task automatic step(input bit opt, input bit up, input bit both);
    logic a, b, ta, tb;
    @(negedge clk);
    a = opt ? opt_a : enc_a;
    b = opt ? opt_b : enc_b;
    ta = both || ((a == b) == up);
    tb = both || ((a == b) != up);
    if (opt) begin
      {opt_a, opt_b} = {a ^ ta, b ^ tb};
    end else begin
      {enc_a, enc_b} = {a ^ ta, b ^ tb};
    end
    repeat (120) @(negedge clk);
  endtask

  // half period in cycles; even split keeps duty inside the band
  always @(negedge clk) begin
    cnt <= (half != 9'h000 && cnt + 1 < half) ? cnt + 1 : 0;
    if (half == 9'h000) freq <= 1'b0;
    else if (cnt + 1 >= half) freq <= !freq;
  end
endmodule

// [bench/dci_top_assertions.sv]
// timing checks on the drive command-input ports
// assumes function selects hold still and alarm causes stay low at reset release
`timescale 1ns/1ps
module dci_top_assertions #(parameter int GATE_CYC = 1, parameter int RAMP_CYC = 1) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // inputs watched
  input wire logic [7:0] DIN,
  input wire logic [2:0] ENA_SEL,
  input wire logic [2:0] RST_SEL,
  input wire logic [15:0] DECEL_STEP,
  input wire logic [7:0] ALARM_COND,
  input wire logic KEY_RESET,
  // outputs watched
  input wire logic [7:0] INPUT_STATE,
  input wire logic [15:0] OUT_FREQ,
  input wire logic SWITCH_EN,
  input wire logic VOLT_ZERO,
  input wire logic ALARM_ACTIVE,
  input wire logic [7:0] ALARM_CODE,
  input wire logic RESTART_LOCK,
  input wire logic [15:0] ENC_A_POS,
  input wire logic ENC_A_DIR
);
  logic ena_seen;
  logic rst_seen;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  // selected function inputs, after the filter
  assign ena_seen = INPUT_STATE[ENA_SEL];
  assign rst_seen = INPUT_STATE[RST_SEL];

  // coast and alarm steps
  sequence s_coast;
    OUT_FREQ == 16'h0000 && !SWITCH_EN && VOLT_ZERO;
  endsequence
  sequence s_latched;
    ALARM_ACTIVE && (ALARM_CODE & $past(ALARM_COND)) == $past(ALARM_COND);
  endsequence
  sequence s_no_clear;
    ALARM_ACTIVE && !KEY_RESET && rst_seen ##1 rst_seen;
  endsequence

  property p_filter;
    $stable(DIN) && DIN == $past(DIN, 2) |-> ##2 INPUT_STATE == $past(DIN, 2);
  endproperty
  property p_enable_off;
    !ena_seen |-> ##1 s_coast;
  endproperty
  property p_trip;
    ALARM_COND != 8'h00 |=> s_latched ##1 s_coast;
  endproperty
  property p_hold;
    s_no_clear |-> ALARM_ACTIVE;
  endproperty
  property p_lock;
    RESTART_LOCK |-> !SWITCH_EN;
  endproperty
  property p_unlock;
    $fell(RESTART_LOCK) |-> ena_seen;
  endproperty
  // a drop larger than one decel step is only allowed as a coast
  property p_decel;
    OUT_FREQ < $past(OUT_FREQ) && $past(OUT_FREQ) - OUT_FREQ > $past(DECEL_STEP) |-> ##1 !SWITCH_EN;
  endproperty
  property p_enc_step;
    ENC_A_POS != $past(ENC_A_POS) |-> ENC_A_POS - $past(ENC_A_POS) == (ENC_A_DIR ? 16'h0001 : 16'hffff);
  endproperty

  a_filter: assert property (p_filter) else $error("input state lost a steady level");
  a_enable_off: assert property (p_enable_off) else $error("drive active with enable low");
  a_trip: assert property (p_trip) else $error("alarm not latched or drive not off");
  a_hold: assert property (p_hold) else $error("alarm cleared without a request");
  a_lock: assert property (p_lock) else $error("switching while restart locked");
  a_unlock: assert property (p_unlock) else $error("lock released with enable low");
  a_decel: assert property (p_decel) else $error("frequency fell faster than decel");
  a_enc_step: assert property (p_enc_step) else $error("encoder count jumped");
endmodule

bind dci_top dci_top_assertions #(.GATE_CYC(GATE_CYC), .RAMP_CYC(RAMP_CYC)) dci_top_assertions_inst (
  .CLK_SYS, .RST_N, .DIN, .ENA_SEL, .RST_SEL, .DECEL_STEP, .ALARM_COND, .KEY_RESET, .INPUT_STATE,
  .OUT_FREQ, .SWITCH_EN, .VOLT_ZERO, .ALARM_ACTIVE, .ALARM_CODE, .RESTART_LOCK, .ENC_A_POS, .ENC_A_DIR);

// [bench/dci_top_test.sv]
// self-checking bench for the drive command-input logic
// assumes short gate and ramp parameters; encoder and frequency come from the partner
`timescale 1ns/1ps
module dci_top_test;
  logic CLK_SYS, RST_N, ENC_TERM_EN, FREQ_IN_EN, REF_SRC_FREQ, OPT_ENC_EN, KEY_RESET, RETAIN_EN, ENA_CYCLE_EN;
  logic [4:0] din_lo;
  logic [2:0] RUN_SEL, ENA_SEL, RST_SEL;
  logic [15:0] SPEED_REF_IN, ACCEL_STEP, DECEL_STEP, REF_AT_MIN, REF_AT_MAX, OUT_FREQ, ENC_A_POS, ENC_B_POS, FREQ_REF;
  logic [11:0] FREQ_AT_MIN, FREQ_AT_MAX, FREQ_COUNT;
  logic [7:0] ALARM_COND, NV_ALARM, DIN, INPUT_STATE, ALARM_CODE;
  logic [8:0] half;
  logic enc_a, enc_b, OPT_ENC_A, OPT_ENC_B, freq;
  logic SWITCH_EN, VOLT_ZERO, DRIVE_RUN, ALARM_ACTIVE, RESTART_LOCK, ENC_A_DIR, ENC_A_ERR, ENC_B_DIR, ENC_B_ERR;
  logic FREQ_VALID;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int err_a = 0;
  int err_b = 0;

  // fast inputs come from the partner
  assign DIN = {freq, enc_b, enc_a, din_lo};

  dci_top #(.GATE_CYC(5000), .RAMP_CYC(8)) dci_top_inst (.CLK_SYS, .RST_N, .DIN, .RUN_SEL, .ENA_SEL, .RST_SEL,
    .ENC_TERM_EN, .FREQ_IN_EN, .REF_SRC_FREQ, .OPT_ENC_EN, .OPT_ENC_A, .OPT_ENC_B, .SPEED_REF_IN, .ACCEL_STEP,
    .DECEL_STEP, .FREQ_AT_MIN, .FREQ_AT_MAX, .REF_AT_MIN, .REF_AT_MAX, .ALARM_COND, .KEY_RESET, .RETAIN_EN,
    .ENA_CYCLE_EN, .NV_ALARM, .INPUT_STATE, .OUT_FREQ, .SWITCH_EN, .VOLT_ZERO, .DRIVE_RUN, .ALARM_ACTIVE,
    .RESTART_LOCK, .ALARM_CODE, .ENC_A_POS, .ENC_A_DIR, .ENC_A_ERR, .ENC_B_POS, .ENC_B_DIR, .ENC_B_ERR,
    .FREQ_COUNT, .FREQ_REF, .FREQ_VALID);
  dci_partner dci_partner_inst (.clk(CLK_SYS), .half(half), .enc_a(enc_a), .enc_b(enc_b), .opt_a(OPT_ENC_A),
    .opt_b(OPT_ENC_B), .freq(freq));

  // 25 MHz clock
  initial begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end

  // hang guard; the whole run needs about 17000 cycles
  always @(posedge CLK_SYS) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures = failures + 1;
      final_report();
    end
  end

  // the decoder error flag stands one cycle only, so its pulses are counted as they pass
  always @(negedge CLK_SYS) begin
    if (ENC_A_ERR === 1'b1) err_a <= err_a + 1;
    if (ENC_B_ERR === 1'b1) err_b <= err_b + 1;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge CLK_SYS);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic do_reset();
    RST_N = 1'b0;
    cyc(12);
    RST_N = 1'b1;
  endtask
  task automatic final_report();
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    {RST_N, din_lo, KEY_RESET, RETAIN_EN, REF_SRC_FREQ, ALARM_COND, half} = 26'h0;
    {RUN_SEL, ENA_SEL, RST_SEL} = {3'h3, 3'h1, 3'h2};
    {ENC_TERM_EN, FREQ_IN_EN, OPT_ENC_EN, ENA_CYCLE_EN} = 4'hf;
    {SPEED_REF_IN, ACCEL_STEP, DECEL_STEP} = {16'h0040, 16'h0010, 16'h0008};
    {FREQ_AT_MIN, FREQ_AT_MAX, REF_AT_MIN, REF_AT_MAX} = {12'h000, 12'h320, 16'h0010, 16'h0074};
    NV_ALARM = 8'h21;
    do_reset();
    cyc(4);
    // published input levels; run moved to input 3
    din_lo = 5'h16;
    cyc(5);
    chk(16'(INPUT_STATE), 16'h0016);
    din_lo = 5'h1e;
    cyc(60);
    chk(OUT_FREQ, 16'h0040);
    chk(16'({SWITCH_EN, VOLT_ZERO, DRIVE_RUN}), 16'h0005);
    // run removed ramps down while still switching
    din_lo = 5'h16;
    cyc(90);
    chk(16'({OUT_FREQ, SWITCH_EN}), 16'h0001);
    // enable removed coasts far quicker than the ramp could
    din_lo = 5'h1e;
    cyc(60);
    din_lo = 5'h1c;
    cyc(6);
    chk(16'({OUT_FREQ, SWITCH_EN, VOLT_ZERO}), 16'h0001);
    // alarm trip, refused clear, clear by opening reset input, enable cycle
    din_lo = 5'h1e;
    cyc(60);
    ALARM_COND = 8'h04;
    cyc(3);
    chk(16'({ALARM_CODE, SWITCH_EN}), 16'h0008);
    chk(OUT_FREQ, 16'h0000);
    KEY_RESET = 1'b1;
    cyc(1);
    KEY_RESET = 1'b0;
    cyc(2);
    chk(16'(ALARM_ACTIVE), 16'h0001);
    ALARM_COND = 8'h00;
    din_lo = 5'h1a;
    cyc(5);
    din_lo = 5'h1e;
    cyc(10);
    chk(16'({ALARM_CODE, RESTART_LOCK, SWITCH_EN}), 16'h0002);
    din_lo = 5'h1c;
    cyc(5);
    din_lo = 5'h1e;
    cyc(10);
    chk(16'({RESTART_LOCK, SWITCH_EN}), 16'h0001);
    // stored alarm comes back at power-up and locks; keypad clears it
    din_lo = 5'h00;
    RETAIN_EN = 1'b1;
    cyc(8);
    do_reset();
    cyc(2);
    chk(16'(ALARM_CODE), 16'h0021);
    din_lo = 5'h1e;
    cyc(10);
    chk(16'(SWITCH_EN), 16'h0000);
    KEY_RESET = 1'b1;
    cyc(1);
    KEY_RESET = 1'b0;
    cyc(3);
    chk(16'({ALARM_ACTIVE, RESTART_LOCK}), 16'h0001);
    din_lo = 5'h1c;
    cyc(5);
    din_lo = 5'h1e;
    cyc(10);
    // terminal encoder 4 up, then 2 down while the option encoder steps 3 down
    for (int i = 0; i < 4; i++) dci_partner_inst.step(1'b0, 1'b1, 1'b0);
    fork
      for (int i = 0; i < 2; i++) dci_partner_inst.step(1'b0, 1'b0, 1'b0);
      for (int j = 0; j < 3; j++) dci_partner_inst.step(1'b1, 1'b0, 1'b0);
    join
    chk(ENC_A_POS, 16'h0002);
    chk(ENC_B_POS, 16'hfffd);
    chk(16'({ENC_A_DIR, ENC_B_DIR}), 16'h0000);
    dci_partner_inst.step(1'b0, 1'b1, 1'b1);
    chk(ENC_A_POS, 16'h0002);
    chk(16'(err_a), 16'h0001);
    chk(16'(err_b), 16'h0000);
    // a disabled decoder keeps tracking levels but never counts
    ENC_TERM_EN = 1'b0;
    dci_partner_inst.step(1'b0, 1'b1, 1'b0);
    ENC_TERM_EN = 1'b1;
    cyc(2);
    chk(ENC_A_POS, 16'h0002);
    // without the enable-cycle demand a clear lets the drive run again at once
    ENA_CYCLE_EN = 1'b0;
    ALARM_COND = 8'h02;
    cyc(2);
    ALARM_COND = 8'h00;
    KEY_RESET = 1'b1;
    cyc(1);
    KEY_RESET = 1'b0;
    cyc(4);
    chk(16'({ALARM_ACTIVE, RESTART_LOCK, SWITCH_EN}), 16'h0001);
    // 100 kHz gives 19..21 edges a gate, all mapping to 16 + 2
    half = 9'h07d;
    cyc(10200);
    chk(FREQ_REF, 16'h0012);
    chk(16'(FREQ_COUNT >= 12'h013 && FREQ_COUNT <= 12'h015), 16'h0001);
    chk(16'(FREQ_VALID), 16'h0000);
    FREQ_AT_MAX = 12'h00a;
    cyc(5100);
    chk(FREQ_REF, 16'h0074);
    REF_SRC_FREQ = 1'b1;
    cyc(100);
    chk(OUT_FREQ, 16'h0074);
    final_report();
  end
endmodule

// [verilog/dci_pkg.sv]
// constants, limits and state codes shared by the drive command-input logic
// assumes a single 25 MHz system clock; all pins arrive synchronous to it
//
// What this block does
// R1 - run input passes main reference; inactive forces zero, frequency ramps down at decel rate
// R2 - drive operates only while the output-enable input is active, in every mode
// R3 - enable inactive: output voltage zero, switching suppressed, motor coasts
// R4 - any alarm trip latches, switches outputs off, raises alarm indication
// R5 - alarm clears on opening reset input or keypad key, only once cause is gone
// R6 - after an alarm clear, restart waits until enable input has been cycled
// R7 - latched alarm is restored at power-up and keeps the drive locked
// R8 - current logic state of every digital input is published as a measurement
// R9 - inputs are assignable; run, enable and reset roles selectable, encoder and frequency fixed on inputs 5, 6 and 7
// R10 - encoder channels A and B are decoded from the two designated fast inputs
// R11 - fast inputs accept encoder rates up to 155 kHz (1024 lines, 9000 rpm)
// R12 - two independent encoder channels: terminal inputs and optional board
// R13 - frequency input measures 10 kHz to 100 kHz square wave into a reference
// R14 - frequencies for minimum and maximum reference are programmable
// R15 - frequency source keeps duty cycle between 30 and 70 percent
// R16 - fast inputs detect high pulses down to 4.5 us; sources hold that long
// R17 - encoder phase order gives direction; both channels changing at once is ignored
// R18 - conversion is linear between programmed points, clamped outside them
package dci_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_NS = 40;
  localparam int NUM_IN = 8;
  localparam logic [2:0] IN_START = 3'h0;
  localparam logic [2:0] IN_ENABLE = 3'h1;
  localparam logic [2:0] IN_RESET = 3'h2;
  localparam logic [2:0] IN_ENC_A = 3'h5;
  localparam logic [2:0] IN_ENC_B = 3'h6;
  localparam logic [2:0] IN_FREQ = 3'h7;
  // fast input pulse limits
  localparam int MIN_HIGH_NS = 4500;
  localparam int MIN_HIGH_CYC = (MIN_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int FILT_LEN = 3;
  localparam int ENC_MAX_HZ = 155_000;
  localparam int ENC_LINES = 1024;
  localparam int ENC_RPM = 9000;
  // frequency reference input
  localparam int FREQ_MIN_HZ = 10_000;
  localparam int FREQ_MAX_HZ = 100_000;
  localparam int GATE_MS = 10;
  localparam int GATE_CYC = CLK_HZ / 1000 * GATE_MS;
  localparam int RAMP_MS = 1;
  localparam int RAMP_CYC = CLK_HZ / 1000 * RAMP_MS;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] VALID_LO = CNT_W'(FREQ_MIN_HZ / 1000 * GATE_MS);
  localparam logic [CNT_W-1:0] VALID_HI = CNT_W'(FREQ_MAX_HZ / 1000 * GATE_MS);
  localparam int REF_W = 16;
  localparam int POS_W = 16;
  localparam int ALM_W = 8;
  localparam int PROD_W = CNT_W + REF_W;
  localparam logic [4:0] DIV_STEPS = 5'h1c;
  typedef enum logic [1:0] {
    DV_IDLE = 2'b00,
    DV_RUN = 2'b01,
    DV_DONE = 2'b10
  } dci_div_t;
endpackage

// [verilog/dci_qdec.sv]
// quadrature decoder for one incremental encoder channel pair
// assumes channel levels already filtered and synchronous to clk
`timescale 1ns/1ps
module dci_qdec (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // channels
  input wire logic enable,
  input wire logic ch_a,
  input wire logic ch_b,
  // results
  output logic [dci_pkg::POS_W-1:0] pos,
  output logic dir_up,
  output logic err
);
  logic pa_ff, pb_ff, up_ff, err_ff;
  logic nxt_pa, nxt_pb, nxt_up, nxt_err;
  logic [dci_pkg::POS_W-1:0] pos_ff, nxt_pos;
  logic ca, cb;

  // one step per single-channel edge; a-leading order counts up
  always_comb begin
    ca = pa_ff ^ ch_a;
    cb = pb_ff ^ ch_b;
    nxt_pa = ch_a;
    nxt_pb = ch_b;
    nxt_pos = pos_ff;
    nxt_up = up_ff;
    nxt_err = 1'b0;
    if (enable) begin
      if (ca & cb) begin
        nxt_err = 1'b1; // both moved: no direction known, count held [R17]
      end else if (ca | cb) begin
        nxt_up = ch_a ^ pb_ff; // [R17]
        nxt_pos = (ch_a ^ pb_ff) ? pos_ff + 1'b1 : pos_ff - 1'b1; // [R10]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pa_ff <= 1'b0;
      pb_ff <= 1'b0;
      pos_ff <= '0;
      up_ff <= 1'b1;
      err_ff <= 1'b0;
    end else begin
      pa_ff <= nxt_pa;
      pb_ff <= nxt_pb;
      pos_ff <= nxt_pos;
      up_ff <= nxt_up;
      err_ff <= nxt_err;
    end
  end

  assign pos = pos_ff;
  assign dir_up = up_ff;
  assign err = err_ff;
endmodule

// [verilog/dci_top.sv]
// drive command-input logic: input filter, run gating, enable, alarm latch,
// two encoder decoders and the frequency-to-reference converter
// assumes pins synchronous to CLK_SYS; alarm store lives in external memory
`timescale 1ns/1ps
module dci_top #(
  parameter int GATE_CYC = dci_pkg::GATE_CYC,
  parameter int RAMP_CYC = dci_pkg::RAMP_CYC
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // terminal inputs and their function selection
  input wire logic [dci_pkg::NUM_IN-1:0] DIN,
  input wire logic [2:0] RUN_SEL,
  input wire logic [2:0] ENA_SEL,
  input wire logic [2:0] RST_SEL,
  input wire logic ENC_TERM_EN,
  input wire logic FREQ_IN_EN,
  input wire logic REF_SRC_FREQ,
  // optional board encoder
  input wire logic OPT_ENC_EN,
  input wire logic OPT_ENC_A,
  input wire logic OPT_ENC_B,
  // speed reference and ramp
  input wire logic [dci_pkg::REF_W-1:0] SPEED_REF_IN,
  input wire logic [dci_pkg::REF_W-1:0] ACCEL_STEP,
  input wire logic [dci_pkg::REF_W-1:0] DECEL_STEP,
  // frequency input scaling, in counts per gate
  input wire logic [dci_pkg::CNT_W-1:0] FREQ_AT_MIN,
  input wire logic [dci_pkg::CNT_W-1:0] FREQ_AT_MAX,
  input wire logic [dci_pkg::REF_W-1:0] REF_AT_MIN,
  input wire logic [dci_pkg::REF_W-1:0] REF_AT_MAX,
  // alarms
  input wire logic [dci_pkg::ALM_W-1:0] ALARM_COND,
  input wire logic KEY_RESET,
  input wire logic RETAIN_EN,
  input wire logic ENA_CYCLE_EN,
  input wire logic [dci_pkg::ALM_W-1:0] NV_ALARM,
  // drive status
  output logic [dci_pkg::NUM_IN-1:0] INPUT_STATE,
  output logic [dci_pkg::REF_W-1:0] OUT_FREQ,
  output logic SWITCH_EN,
  output logic VOLT_ZERO,
  output logic DRIVE_RUN,
  output logic ALARM_ACTIVE,
  output logic RESTART_LOCK,
  output logic [dci_pkg::ALM_W-1:0] ALARM_CODE,
  // encoders
  output logic [dci_pkg::POS_W-1:0] ENC_A_POS,
  output logic ENC_A_DIR,
  output logic ENC_A_ERR,
  output logic [dci_pkg::POS_W-1:0] ENC_B_POS,
  output logic ENC_B_DIR,
  output logic ENC_B_ERR,
  // frequency reference
  output logic [dci_pkg::CNT_W-1:0] FREQ_COUNT,
  output logic [dci_pkg::REF_W-1:0] FREQ_REF,
  output logic FREQ_VALID
);
  localparam int GW = $clog2(GATE_CYC + 1);
  localparam int RW = $clog2(RAMP_CYC + 1);
  localparam int REF_W = dci_pkg::REF_W;
  localparam int CNT_W = dci_pkg::CNT_W;
  localparam int PROD_W = dci_pkg::PROD_W;

  logic [dci_pkg::NUM_IN-1:0] filt;

  // per-input spike filter: a level is taken once it holds for three samples,
  // far shorter than the narrowest legal fast pulse, so none is lost [R16] [R11]
  genvar gi;
  generate
    for (gi = 0; gi < dci_pkg::NUM_IN; gi++) begin : g_in
      logic [dci_pkg::FILT_LEN-1:0] sh_ff, nxt_sh;
      logic lv_ff, nxt_lv;
      always_comb begin
        nxt_sh = {sh_ff[dci_pkg::FILT_LEN-2:0], DIN[gi]};
        nxt_lv = lv_ff;
        if (&sh_ff) begin
          nxt_lv = 1'b1;
        end else if (~|sh_ff) begin
          nxt_lv = 1'b0;
        end
      end
      always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          sh_ff <= '0;
          lv_ff <= 1'b0;
        end else begin
          sh_ff <= nxt_sh;
          lv_ff <= nxt_lv;
        end
      end
      assign filt[gi] = lv_ff;
    end
  endgenerate

  assign INPUT_STATE = filt; // filtered levels, one bit per terminal, 1 = active [R8]

  // function assignment; all inputs stay readable whatever role they take
  logic run_in, ena_in, rst_in;
  assign run_in = filt[RUN_SEL]; // [R9]
  assign ena_in = filt[ENA_SEL]; // [R9]
  assign rst_in = filt[RST_SEL]; // [R9]

  // alarm latch, power-up restore and enable-cycle lock
  logic [dci_pkg::ALM_W-1:0] alarm_ff, nxt_alarm;
  logic boot_ff, nxt_boot, lock_ff, nxt_lock, off_ff, nxt_off, rstp_ff, nxt_rstp;
  logic clr_req;

  always_comb begin
    nxt_boot = 1'b1;
    nxt_rstp = rst_in;
    nxt_alarm = alarm_ff;
    nxt_lock = lock_ff;
    nxt_off = off_ff;
    // reset input opening, or keypad key, while no cause remains [R5]
    clr_req = ((rstp_ff & ~rst_in) | KEY_RESET) & ~|ALARM_COND;
    if (!boot_ff) begin
      nxt_alarm = RETAIN_EN ? NV_ALARM : '0; // stored alarm reappears at power-up [R7]
    end else begin
      if (clr_req && |alarm_ff) begin
        nxt_alarm = '0; // [R5]
        nxt_lock = ENA_CYCLE_EN; // [R6]
        nxt_off = 1'b0;
      end
      nxt_alarm = nxt_alarm | ALARM_COND; // a new trip beats a clear [R4]
    end
    if (lock_ff) begin
      if (!ena_in) begin
        nxt_off = 1'b1;
      end else if (off_ff) begin
        nxt_lock = 1'b0; // enable went off and back on [R6]
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      boot_ff <= 1'b0;
      rstp_ff <= 1'b0;
      alarm_ff <= '0;
      lock_ff <= 1'b0;
      off_ff <= 1'b0;
    end else begin
      boot_ff <= nxt_boot;
      rstp_ff <= nxt_rstp;
      alarm_ff <= nxt_alarm;
      lock_ff <= nxt_lock;
      off_ff <= nxt_off;
    end
  end

  // drive permission: enable present, no alarm, no pending enable cycle
  logic run_ok;
  assign run_ok = ena_in & ~|alarm_ff & ~lock_ff & boot_ff; // [R2] [R4]

  // ramp tick divider; a coarse step rate keeps the ramp adder narrow
  logic [RW-1:0] rdiv_ff, nxt_rdiv;
  logic tick;
  logic [REF_W-1:0] freq_ff, nxt_freq, ref_sel, target, gap;
  logic sw_ff, nxt_sw, dr_ff, nxt_dr;
  logic [REF_W-1:0] fref_ff;

  always_comb begin
    tick = (rdiv_ff == RW'(RAMP_CYC - 1));
    nxt_rdiv = tick ? '0 : rdiv_ff + 1'b1;
    ref_sel = REF_SRC_FREQ ? fref_ff : SPEED_REF_IN;
    target = run_in ? ref_sel : '0; // run gates the main reference [R1]
    gap = (freq_ff > target) ? freq_ff - target : target - freq_ff;
    nxt_freq = freq_ff;
    if (!run_ok) begin
      nxt_freq = '0; // coast: no ramp, output dropped at once [R3] [R4]
    end else if (tick) begin
      if (freq_ff > target) begin
        nxt_freq = (gap > DECEL_STEP) ? freq_ff - DECEL_STEP : target; // [R1]
      end else begin
        nxt_freq = (gap > ACCEL_STEP) ? freq_ff + ACCEL_STEP : target;
      end
    end
    nxt_sw = run_ok; // switching commands only while permitted [R3] [R2]
    nxt_dr = run_ok & (run_in | (freq_ff != '0));
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rdiv_ff <= '0;
      freq_ff <= '0;
      sw_ff <= 1'b0;
      dr_ff <= 1'b0;
    end else begin
      rdiv_ff <= nxt_rdiv;
      freq_ff <= nxt_freq;
      sw_ff <= nxt_sw;
      dr_ff <= nxt_dr;
    end
  end

  assign OUT_FREQ = freq_ff;
  assign SWITCH_EN = sw_ff;
  assign VOLT_ZERO = ~sw_ff; // [R3]
  assign DRIVE_RUN = dr_ff;
  assign ALARM_ACTIVE = |alarm_ff; // display indication [R4]
  assign ALARM_CODE = alarm_ff;
  assign RESTART_LOCK = lock_ff;

  // encoder on terminal fast inputs, and the independent option-board one
  dci_qdec u_enc_a (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .enable(ENC_TERM_EN),
    .ch_a(filt[dci_pkg::IN_ENC_A]), // [R10]
    .ch_b(filt[dci_pkg::IN_ENC_B]), // [R10]
    .pos(ENC_A_POS),
    .dir_up(ENC_A_DIR),
    .err(ENC_A_ERR)
  );

  dci_qdec u_enc_b (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .enable(OPT_ENC_EN), // both channels run side by side [R12]
    .ch_a(OPT_ENC_A),
    .ch_b(OPT_ENC_B),
    .pos(ENC_B_POS),
    .dir_up(ENC_B_DIR),
    .err(ENC_B_ERR)
  );

  // frequency input: rising edges counted over a fixed gate window [R13]
  logic [GW-1:0] gate_ff, nxt_gate;
  logic [CNT_W-1:0] ecnt_ff, nxt_ecnt, fcnt_ff, nxt_fcnt;
  logic fp_ff, nxt_fp, gate_end, val_ff, nxt_val;
  // restoring divider for the linear map
  dci_pkg::dci_div_t dst_ff, nxt_dst;
  logic [PROD_W-1:0] num_ff, nxt_num;
  logic [CNT_W:0] rem_ff, nxt_rem;
  logic [CNT_W:0] trial;
  logic [4:0] step_ff, nxt_step;
  logic [REF_W-1:0] nxt_fref;
  logic [CNT_W-1:0] den;
  logic [REF_W-1:0] span;

  always_comb begin
    gate_end = (gate_ff == GW'(GATE_CYC - 1));
    nxt_gate = gate_end ? '0 : gate_ff + 1'b1;
    nxt_fp = filt[dci_pkg::IN_FREQ];
    nxt_ecnt = ecnt_ff;
    if (gate_end) begin
      nxt_ecnt = '0;
    end else if (FREQ_IN_EN && nxt_fp && !fp_ff && !(&ecnt_ff)) begin
      nxt_ecnt = ecnt_ff + 1'b1; // saturates rather than wrapping
    end
    nxt_fcnt = gate_end ? ecnt_ff : fcnt_ff;
    nxt_val = gate_end ? (ecnt_ff >= dci_pkg::VALID_LO && ecnt_ff <= dci_pkg::VALID_HI) : val_ff;
    den = FREQ_AT_MAX - FREQ_AT_MIN;
    span = REF_AT_MAX - REF_AT_MIN;
    trial = {rem_ff[CNT_W-1:0], num_ff[PROD_W-1]};
    nxt_dst = dst_ff;
    nxt_num = num_ff;
    nxt_rem = rem_ff;
    nxt_step = step_ff;
    nxt_fref = fref_ff;
    case (dst_ff)
      dci_pkg::DV_IDLE: begin
        if (gate_end) begin
          if (FREQ_AT_MAX <= FREQ_AT_MIN || ecnt_ff <= FREQ_AT_MIN) begin
            nxt_fref = REF_AT_MIN; // below the low point, or no usable span [R18]
          end else if (ecnt_ff >= FREQ_AT_MAX) begin
            nxt_fref = REF_AT_MAX; // [R18]
          end else begin
            nxt_num = PROD_W'((ecnt_ff - FREQ_AT_MIN) * span); // [R14]
            nxt_rem = '0;
            nxt_step = '0;
            nxt_dst = dci_pkg::DV_RUN;
          end
        end
      end
      dci_pkg::DV_RUN: begin
        if (trial >= {1'b0, den}) begin
          nxt_rem = trial - {1'b0, den};
          nxt_num = {num_ff[PROD_W-2:0], 1'b1};
        end else begin
          nxt_rem = trial;
          nxt_num = {num_ff[PROD_W-2:0], 1'b0};
        end
        nxt_step = step_ff + 1'b1;
        if (step_ff == dci_pkg::DIV_STEPS - 1'b1) begin
          nxt_dst = dci_pkg::DV_DONE;
        end
      end
      dci_pkg::DV_DONE: begin
        // quotient never exceeds span, so the low bits hold it whole
        nxt_fref = REF_AT_MIN + num_ff[REF_W-1:0]; // linear map [R18] [R14]
        nxt_dst = dci_pkg::DV_IDLE;
      end
      default: begin
        nxt_dst = dci_pkg::DV_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      gate_ff <= '0;
      ecnt_ff <= '0;
      fcnt_ff <= '0;
      fp_ff <= 1'b0;
      val_ff <= 1'b0;
      dst_ff <= dci_pkg::DV_IDLE;
      num_ff <= '0;
      rem_ff <= '0;
      step_ff <= '0;
      fref_ff <= '0;
    end else begin
      gate_ff <= nxt_gate;
      ecnt_ff <= nxt_ecnt;
      fcnt_ff <= nxt_fcnt;
      fp_ff <= nxt_fp;
      val_ff <= nxt_val;
      dst_ff <= nxt_dst;
      num_ff <= nxt_num;
      rem_ff <= nxt_rem;
      step_ff <= nxt_step;
      fref_ff <= nxt_fref;
    end
  end

  assign FREQ_COUNT = fcnt_ff;
  assign FREQ_REF = fref_ff;
  assign FREQ_VALID = val_ff;
endmodule
